// file: inc/wlc_pkg.sv
// constants and types shared by the latch and learning-pattern command block
package wlc_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_LATCH_SET    = 8'h06;
  localparam logic [7:0] OPC_LATCH_CLEAR  = 8'h04;
  localparam logic [7:0] OPC_VOL_STEER    = 8'h50;
  localparam logic [7:0] OPC_STATUS_CLEAR = 8'h30;
  localparam logic [7:0] OPC_NV_PROGRAM   = 8'h43;
  localparam logic [7:0] OPC_VOL_WRITE    = 8'h4A;
  localparam logic [7:0] OPC_PATTERN_READ = 8'h41;

  // ----------------------------------------------------------------
  // frame lengths in serial clocks, output beat reloads and output enables (single line / four lines)
  // ----------------------------------------------------------------
  localparam logic [7:0] INSTR_CLKS_SINGLE = 8'h08;
  localparam logic [7:0] INSTR_CLKS_QUAD   = 8'h02;
  localparam logic [7:0] DATA_CLKS_SINGLE  = 8'h10;
  localparam logic [7:0] DATA_CLKS_QUAD    = 8'h04;
  localparam logic [7:0] DUMMY_CLKS        = 8'h01;
  localparam logic [2:0] BEATS_SINGLE      = 3'h7;
  localparam logic [2:0] BEATS_QUAD        = 3'h1;
  localparam logic [3:0] OE_SINGLE         = 4'h2;
  localparam logic [3:0] OE_QUAD           = 4'hF;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          NV_PROG_TIME_NS  = 50000;
  localparam int          NV_PROG_CYCLES   = NV_PROG_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  NV_LEARN_RESET   = 8'h00;
  localparam logic [23:0] PROG_CNT_RESET   = 24'h000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        quad;
    logic [7:0]  clks;
    logic [15:0] bits;
  } wlc_frame_t;

  typedef struct packed {
    logic eraseErr;
    logic progErr;
    logic writeLatch;
    logic busy;
  } wlc_status_t;

  typedef enum logic {PRG_IDLE, PRG_RUN} wlc_prog_state_t;

endpackage

// file: verilog/wlc_cmd_decoder.sv
// latch, status-clear and learning-pattern command decoder
// ------------------------------------------------------------------
// Summary of operation
// (R1) latch-set 06h sets the write latch flag
// (R2) program and write commands accepted only while the write latch is one
// (R3) latch-set, latch-clear, steer execute only if chip select rises after bit eight
// (R4) latch-clear 04h clears the write latch flag
// (R5) latch-clear ignored while busy flag is one
// (R6) steer 50h keeps write latch, directs next register write to volatile registers
// (R7) status-clear 30h clears busy, write latch, program and erase error flags
// (R8) status-clear needs no latch-set and works while busy
// (R9) busy stays one while either error flag is set
// (R10) nv learning program 43h needs latch, one data byte, exact length
// (R11) nv learning program is self-timed, busy one until complete
// (R12) failed nv learning program sets the program error flag
// (R13) completed nv learning program clears the write latch
// (R14) host keeps serial clock at or below 133 MHz for these commands
// (R15) vol learning write 4Ah needs latch, one data byte, exact length
// (R16) vol learning write updates the register at once, no busy time
// (R17) pattern read 41h: one dummy clock then the 8-bit pattern out
// (R18) data lines are don't-care during the dummy clock
// (R19) pattern repeats every eight clocks while chip select stays low; four-line mode repeats it every two clocks
// (R20) four-line mode takes and returns everything on four lines
// (R21) failed register write sets error, busy held until status-clear
// (R22) vol learning register loads from nv register at reset; read returns it
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module wlc_cmd_decoder #(
  parameter int unsigned NV_PROG_CYCLES = wlc_pkg::NV_PROG_CYCLES
) (
  // system
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  // serial link
  input  wire logic               linkClk,
  input  wire logic               csN,
  input  wire logic [3:0]         ioIn,
  output logic      [3:0]         ioOut,
  output logic      [3:0]         ioOe,
  // configuration and events from neighbouring logic
  input  wire logic               fourLineMode,
  input  wire logic               nvProgFail,
  input  wire logic               regWriteFailProg,
  input  wire logic               regWriteFailErase,
  input  wire logic               regWriteDone,
  // status
  output wlc_pkg::wlc_status_t    status,
  output logic                    volSteer,
  output logic      [7:0]         volLearningReg,
  output logic      [7:0]         nvLearningReg
);

  // ----------------------------------------------------------------
  // link side: mode sync, clock count, input shift
  // ----------------------------------------------------------------
  logic              modeMeta_reg;
  logic              modeSync_reg;
  logic [7:0]        clkCnt_reg;
  logic [7:0]        clkCnt_next;
  wlc_pkg::wlc_frame_t frame_reg;
  logic [15:0]       shiftIn_next;
  logic [7:0]        instrClks;
  logic              isRead_reg;
  logic [2:0]        beat_reg;
  logic [7:0]        patShift_reg;
  logic [3:0]        ioOut_reg;
  logic [3:0]        ioOe_reg;

  always_ff @(posedge linkClk or posedge sys_rst) begin
    if (sys_rst) begin
      modeMeta_reg <= 1'b0;
      modeSync_reg <= 1'b0;
    end else begin
      modeMeta_reg <= fourLineMode;
      modeSync_reg <= modeMeta_reg;
    end
  end

  assign instrClks = modeSync_reg ? wlc_pkg::INSTR_CLKS_QUAD : wlc_pkg::INSTR_CLKS_SINGLE;
  assign clkCnt_next = (clkCnt_reg == 8'hFF) ? clkCnt_reg : clkCnt_reg + 8'h01;

  // four lines in four-line mode, line 0 otherwise
  always_comb begin
    if (modeSync_reg) begin
      shiftIn_next = {frame_reg.bits[11:0], ioIn};  // see (R20)
    end else begin
      shiftIn_next = {frame_reg.bits[14:0], ioIn[0]};
    end
  end

  // clock count restarts with every frame
  always_ff @(posedge linkClk or posedge csN or posedge sys_rst) begin
    if (sys_rst || csN) begin
      clkCnt_reg <= 8'h00;
    end else begin
      clkCnt_reg <= clkCnt_next;
    end
  end

  // frame record survives chip select so the core can judge it
  always_ff @(posedge linkClk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_reg <= '0;
    end else begin
      frame_reg.quad <= modeSync_reg;
      frame_reg.clks <= clkCnt_next;
      frame_reg.bits <= shiftIn_next;
    end
  end

  // pattern read recognised on last instruction clock
  always_ff @(posedge linkClk or posedge csN or posedge sys_rst) begin
    if (sys_rst || csN) begin
      isRead_reg <= 1'b0;
    end else if (clkCnt_reg == instrClks - 8'h01) begin
      isRead_reg <= (shiftIn_next[7:0] == wlc_pkg::OPC_PATTERN_READ);  // see (R17)
    end
  end

  // ----------------------------------------------------------------
  // link side: pattern output on falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge linkClk or posedge csN or posedge sys_rst) begin
    if (sys_rst || csN) begin
      beat_reg     <= 3'h0;
      patShift_reg <= 8'h00;
      ioOut_reg    <= 4'h0;
      ioOe_reg     <= 4'h0;
    end else if (isRead_reg && clkCnt_reg >= instrClks + wlc_pkg::DUMMY_CLKS) begin  // see (R18)
      ioOe_reg <= modeSync_reg ? wlc_pkg::OE_QUAD : wlc_pkg::OE_SINGLE;  // see (R20)
      if (beat_reg == 3'h0) begin
        // reload each byte so the pattern repeats
        beat_reg <= modeSync_reg ? wlc_pkg::BEATS_QUAD : wlc_pkg::BEATS_SINGLE;  // see (R19)
        if (modeSync_reg) begin
          ioOut_reg    <= volLearningReg[7:4];  // see (R20)
          patShift_reg <= {volLearningReg[3:0], 4'h0};
        end else begin
          ioOut_reg    <= {2'h0, volLearningReg[7], 1'b0};  // see (R17)
          patShift_reg <= {volLearningReg[6:0], 1'b0};
        end
      end else begin
        beat_reg <= beat_reg - 3'h1;
        if (modeSync_reg) begin
          ioOut_reg    <= patShift_reg[7:4];
          patShift_reg <= {patShift_reg[3:0], 4'h0};
        end else begin
          ioOut_reg    <= {2'h0, patShift_reg[7], 1'b0};
          patShift_reg <= {patShift_reg[6:0], 1'b0};
        end
      end
    end else begin
      ioOe_reg <= 4'h0;
    end
  end

  assign ioOut = ioOut_reg;
  assign ioOe  = ioOe_reg;

  // ----------------------------------------------------------------
  // core side: chip select sync and frame decode
  // ----------------------------------------------------------------
  logic        csMeta_reg;
  logic        csSync_reg;
  logic        csPrev_reg;
  logic        frameEnd;
  logic        lenInstr;
  logic        lenData;
  logic [7:0]  opcInstr;
  logic [7:0]  opcData;
  logic [7:0]  dataByte;
  logic        cmdSet;
  logic        cmdClear;
  logic        cmdSteer;
  logic        cmdStatClr;
  logic        cmdNvProg;
  logic        cmdVolWr;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      csMeta_reg <= 1'b1;
      csSync_reg <= 1'b1;
      csPrev_reg <= 1'b1;
    end else begin
      csMeta_reg <= csN;
      csSync_reg <= csMeta_reg;
      csPrev_reg <= csSync_reg;
    end
  end

  assign frameEnd = csSync_reg & ~csPrev_reg;
  assign lenInstr = frame_reg.clks ==
                    (frame_reg.quad ? wlc_pkg::INSTR_CLKS_QUAD : wlc_pkg::INSTR_CLKS_SINGLE);
  assign lenData  = frame_reg.clks ==
                    (frame_reg.quad ? wlc_pkg::DATA_CLKS_QUAD : wlc_pkg::DATA_CLKS_SINGLE);
  assign opcInstr = frame_reg.bits[7:0];
  assign opcData  = frame_reg.bits[15:8];
  assign dataByte = frame_reg.bits[7:0];

  assign cmdSet     = frameEnd & lenInstr & (opcInstr == wlc_pkg::OPC_LATCH_SET);   // see (R3)
  assign cmdClear   = frameEnd & lenInstr & (opcInstr == wlc_pkg::OPC_LATCH_CLEAR); // see (R3)
  assign cmdSteer   = frameEnd & lenInstr & (opcInstr == wlc_pkg::OPC_VOL_STEER);   // see (R3)
  assign cmdStatClr = frameEnd & lenInstr & (opcInstr == wlc_pkg::OPC_STATUS_CLEAR); // see (R8)
  assign cmdNvProg  = frameEnd & lenData & (opcData == wlc_pkg::OPC_NV_PROGRAM)
                      & status.writeLatch & ~status.busy;  // see (R2) (R10)
  assign cmdVolWr   = frameEnd & lenData & (opcData == wlc_pkg::OPC_VOL_WRITE)
                      & status.writeLatch & ~status.busy;  // see (R2) (R15)

  // ----------------------------------------------------------------
  // core side: self-timed nv program
  // ----------------------------------------------------------------
  wlc_pkg::wlc_prog_state_t progState_reg;
  logic [23:0] progCnt_reg;
  logic [7:0]  progData_reg;
  logic        progDone;
  logic        progFailNow;

  assign progDone    = (progState_reg == wlc_pkg::PRG_RUN) && (progCnt_reg == 24'h000000);
  assign progFailNow = progDone & nvProgFail;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      progState_reg <= wlc_pkg::PRG_IDLE;
      progCnt_reg   <= wlc_pkg::PROG_CNT_RESET;
      progData_reg  <= wlc_pkg::NV_LEARN_RESET;
    end else begin
      case (progState_reg)
        wlc_pkg::PRG_IDLE: begin
          if (cmdNvProg) begin
            progState_reg <= wlc_pkg::PRG_RUN;  // see (R11)
            progCnt_reg   <= 24'(NV_PROG_CYCLES - 1);
            progData_reg  <= dataByte;
          end
        end
        wlc_pkg::PRG_RUN: begin
          if (cmdStatClr || progDone) begin
            progState_reg <= wlc_pkg::PRG_IDLE;
          end else begin
            progCnt_reg <= progCnt_reg - 24'h000001;
          end
        end
        default: begin
          progState_reg <= wlc_pkg::PRG_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // core side: status flags
  // ----------------------------------------------------------------
  logic progErr_next;
  logic eraseErr_next;
  logic busy_next;
  logic wel_next;

  always_comb begin
    // a fresh error wins over a clear in the same cycle
    progErr_next  = (status.progErr & ~cmdStatClr) | progFailNow | regWriteFailProg;  // see (R12) (R21) (R7)
    eraseErr_next = (status.eraseErr & ~cmdStatClr) | regWriteFailErase;  // see (R21) (R7)
    busy_next     = progErr_next | eraseErr_next | cmdNvProg  // see (R9)
                    | ((progState_reg == wlc_pkg::PRG_RUN) & ~progDone & ~cmdStatClr);  // see (R11)
    wel_next      = status.writeLatch;
    if (cmdStatClr) begin
      wel_next = 1'b0;  // see (R7)
    end else if (cmdSet) begin
      wel_next = 1'b1;  // see (R1)
    end else if (cmdClear && !status.busy) begin
      wel_next = 1'b0;  // see (R4) (R5)
    end else if (progDone) begin
      wel_next = 1'b0;  // see (R13)
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status.progErr    <= progErr_next;
      status.eraseErr   <= eraseErr_next;
      status.busy       <= busy_next;
      status.writeLatch <= wel_next;
    end
  end

  // steer flag held until the next register write consumes it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      volSteer <= 1'b0;
    end else if (cmdSteer) begin
      volSteer <= 1'b1;  // see (R6)
    end else if (regWriteDone) begin
      volSteer <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // core side: learning registers
  // ----------------------------------------------------------------
  logic loadPend_reg;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nvLearningReg <= wlc_pkg::NV_LEARN_RESET;
    end else if (progDone && !nvProgFail) begin
      nvLearningReg <= progData_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      loadPend_reg   <= 1'b1;
      volLearningReg <= wlc_pkg::NV_LEARN_RESET;
    end else if (loadPend_reg) begin
      loadPend_reg   <= 1'b0;
      volLearningReg <= nvLearningReg;  // see (R22)
    end else if (cmdVolWr) begin
      volLearningReg <= dataByte;  // see (R16)
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_SET_LATCH: assert property (cmdSet && !cmdStatClr |=> status.writeLatch)  // see (R1)
    else $error("latch-set did not set write latch");
  AST_NO_LATCH_NO_PROG: assert property (
    frameEnd && !status.writeLatch |=> $stable(progState_reg) || progState_reg == wlc_pkg::PRG_IDLE)  // see (R2)
    else $error("program started without write latch");
  AST_LEN_CHECK: assert property (
    frameEnd && !lenInstr && !status.writeLatch |=> !status.writeLatch)  // see (R3)
    else $error("wrong-length frame changed write latch");
  AST_CLEAR_LATCH: assert property (cmdClear && !status.busy |=> !status.writeLatch)  // see (R4)
    else $error("latch-clear did not clear write latch");
  AST_CLEAR_BUSY_IGN: assert property (
    cmdClear && status.busy && !progDone |=> status.writeLatch == $past(status.writeLatch))  // see (R5)
    else $error("latch-clear acted while busy");
  AST_STEER: assert property (
    cmdSteer && !progDone |=> volSteer && status.writeLatch == $past(status.writeLatch))  // see (R6)
    else $error("steer altered write latch or missed steer flag");
  AST_STATUS_CLEAR: assert property (
    cmdStatClr && !regWriteFailProg && !regWriteFailErase && !progFailNow
    |=> !status.busy && !status.writeLatch && !status.progErr && !status.eraseErr)  // see (R7)
    else $error("status-clear left a flag set");
  AST_ERR_BUSY: assert property (status.progErr || status.eraseErr |-> status.busy)  // see (R9)
    else $error("error flag without busy");
  AST_PROG_BUSY: assert property (cmdNvProg |=> status.busy ##1 status.busy)  // see (R11)
    else $error("nv program not busy");
  AST_PROG_FAIL: assert property (progFailNow |=> status.progErr && status.busy)  // see (R12)
    else $error("nv program failure not reported");
  AST_PROG_DONE_WEL: assert property (progDone && !cmdSet |=> !status.writeLatch)  // see (R13)
    else $error("write latch not cleared at program end");
  AST_VOL_WRITE: assert property (
    cmdVolWr && !loadPend_reg |=> volLearningReg == $past(dataByte) && !status.busy)  // see (R16)
    else $error("vol learning write not immediate");

  COV_SET_THEN_PROG: cover property (cmdSet ##[1:200] cmdNvProg);
  COV_PROG_DONE:     cover property (progDone && !nvProgFail);
  COV_ERR_CLEAR:     cover property (status.progErr ##[1:200] cmdStatClr);
  COV_VOL_WRITE:     cover property (cmdVolWr);

endmodule

`default_nettype wire

// file: bench/wlc_host_model.sv
// host serial controller model driving frames into the command block
`timescale 1ns/1ps
`default_nettype none

module wlc_host_model (
  // serial link
  output logic            linkClk,
  output logic            csN,
  output wire logic [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe
);
  logic [3:0] hostDrv;

  // wire level from both drivers
  assign ioIn = (hostDrv & ~ioOe) | (ioOut & ioOe);

  initial begin
    linkClk = 1'b0;
    csN     = 1'b1;
    hostDrv = 4'h0;
  end

  // one framed transfer; rd keeps the last sixteen bits seen on the read lines
  task automatic frame(input wlc_pkg::wlc_frame_t f, output logic [15:0] rd,
                       output logic [3:0] oe);
    logic [15:0] sh;
    sh = f.bits;
    rd = 16'h0000;
    oe = 4'h0;
    csN = 1'b0;
    for (int i = 0; i < f.clks; i++) begin
      // in single-line mode the spare lines carry the inverse of the line 0 bit, so they never follow line 0's level
      hostDrv = f.quad ? sh[15:12] : {{3{~sh[15]}}, sh[15]};
      sh = f.quad ? {sh[11:0], 4'h0} : {sh[14:0], 1'b0};
      #6 linkClk = 1'b1; // 12 ns period, below the clock ceiling
      rd = f.quad ? {rd[11:0], ioOut} : {rd[14:0], ioOut[1]};
      oe = ioOe;
      #6 linkClk = 1'b0;
    end
    // chip select rises right after the last counted clock
    #6 csN = 1'b1;
    hostDrv = ~hostDrv;
  endtask
endmodule

`default_nettype wire

// file: bench/tb_top.sv
// self-checking testbench for the latch and learning-pattern command block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                 ref_clk;
  logic                 sys_rst;
  logic                 fourLineMode;
  logic                 nvProgFail;
  logic                 regWriteFailProg;
  logic                 regWriteFailErase;
  logic                 regWriteDone;
  wire logic            linkClk;
  wire logic            csN;
  wire logic [3:0]      ioIn;
  wire logic [3:0]      ioOut;
  wire logic [3:0]      ioOe;
  wlc_pkg::wlc_status_t status;
  logic                 volSteer;
  logic [7:0]           volLearningReg;
  logic [7:0]           nvLearningReg;
  logic [15:0]          rd;
  logic [3:0]           oe;
  int                   mismatches;
  int                   checked;
  int                   cyc;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  wlc_cmd_decoder #(.NV_PROG_CYCLES(60)) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .linkClk(linkClk), .csN(csN),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .fourLineMode(fourLineMode),
    .nvProgFail(nvProgFail), .regWriteFailProg(regWriteFailProg),
    .regWriteFailErase(regWriteFailErase), .regWriteDone(regWriteDone),
    .status(status), .volSteer(volSteer), .volLearningReg(volLearningReg),
    .nvLearningReg(nvLearningReg)
  );

  wlc_host_model i_host (
    .linkClk(linkClk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fr(input logic q, input logic [7:0] n, input logic [15:0] b);
    @(negedge ref_clk);
    i_host.frame(wlc_pkg::wlc_frame_t'{q, n, b}, rd, oe);
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic pulse(input logic [2:0] s);
    @(negedge ref_clk);
    {regWriteFailErase, regWriteFailProg, regWriteDone} = s;
    @(negedge ref_clk);
    {regWriteFailErase, regWriteFailProg, regWriteDone} = 3'h0;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic endt(input string s);
    $display("test %s ended, mismatches %0d", s, mismatches);
  endtask

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    checked = 0;
    cyc = 0;
    sys_rst = 1'b1;
    {fourLineMode, nvProgFail} = 2'h0;
    {regWriteFailErase, regWriteFailProg, regWriteDone} = 3'h0;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({volLearningReg, nvLearningReg}, 16'h0000);
    chk({12'h000, status}, 16'h0000);
    endt("reset");
    fr(1'b0, 8'h08, 16'h0600);
    chk(status, 4'h2);
    fr(1'b0, 8'h09, 16'h0400);
    chk(status, 4'h2);
    fr(1'b0, 8'h08, 16'h0400);
    chk(status, 4'h0);
    fr(1'b0, 8'h08, 16'h5000);
    chk({volSteer, status}, 5'h10);
    pulse(3'h1);
    chk(volSteer, 1'b0);
    endt("latch");
    fr(1'b0, 8'h10, 16'h4AA5);
    chk(volLearningReg, 8'h00);
    fr(1'b0, 8'h08, 16'h0600);
    fr(1'b0, 8'h10, 16'h4AA5);
    chk({volLearningReg, status}, 12'hA52);
    fr(1'b0, 8'h19, 16'h4100);
    chk(rd, 16'hA5A5);
    chk(oe, 4'h2);
    endt("volatile write and read");
    fr(1'b0, 8'h10, 16'h433C);
    chk(status, 4'h3);
    fr(1'b0, 8'h08, 16'h0400);
    chk(status, 4'h3);
    for (int i = 0; i < 100 && status.busy !== 1'b0; i++) @(negedge ref_clk);
    chk({nvLearningReg, status}, 12'h3C0);
    endt("nv program");
    nvProgFail = 1'b1;
    fr(1'b0, 8'h08, 16'h0600);
    fr(1'b0, 8'h10, 16'h435A);
    repeat (80) @(negedge ref_clk);
    chk(status & 4'h5, 4'h5);
    fr(1'b0, 8'h08, 16'h3000);
    chk(status, 4'h0);
    nvProgFail = 1'b0;
    pulse(3'h6);
    chk(status, 4'hD);
    fr(1'b0, 8'h08, 16'h3000);
    chk(status, 4'h0);
    endt("errors");
    fourLineMode = 1'b1;
    fr(1'b0, 8'h03, 16'hFF00);
    fr(1'b1, 8'h02, 16'h0600);
    chk(status, 4'h2);
    fr(1'b1, 8'h04, 16'h4A96);
    chk(volLearningReg, 8'h96);
    fr(1'b1, 8'h07, 16'h4100);
    chk(rd, 16'h9696);
    chk(oe, 4'hF);
    endt("four-line");
    complete_run();
  end
endmodule

`default_nettype wire
